// *** logic/qis_pkg.sv ***
// Overview of operation
// - Load port counter from low two start address bits at request start
// - After each processor acknowledge, jump counter to next requested word
// - Counter value N selects memory port N
// - Each port carries low address bits equal to the word it serves
// - Ports served in ascending order modulo 4 from the start word
// - One latch per asserted word request; cleared once that word transfers
// - Empty latches drop port cycle requests; end on done flag or ports idle
// - Four-word read raises fast, slow and immediate requests on all ports
// - Port acknowledges and data held per port until that port is selected
// - Selected port acknowledge forwarded on phase A or B
// - Delayed acknowledge and latched select drive that port data out
// - Selected port read restart synchronized then raises data valid A or B
// - Read: at delayed restart advance counter and clear latch of word sent
// - Completion flag set on final word; with empty latches ends read
// - Write: no port requests until first word loaded, then all requested ports
// - Write: port acknowledge gives enable, then pulse driving data and restart
// - Write: delayed acknowledge advances counter and sets cycling flag
// - While cycling, internal acknowledge per port and word strobed to buffer
// - Write finished when all ports not busy; cycling flag then cleared
// - Missing request line at start word is an error
package qis_pkg;
  localparam int NUM_PORTS = 4;
  localparam int DATA_W = 36;
  localparam int CLK_PERIOD_NS = 20;
  localparam int ADV_CLOCK_NS = 62;
  // Advance step is a least time, so round up
  localparam int ADV_CYCLES = (ADV_CLOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_PULSE_DELAY_NS = 60;
  localparam int WR_PULSE_CYCLES =
    (WR_PULSE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] WORD0 = 2'h0;
  localparam logic [3:0] NO_WORDS = 4'h0;

  typedef enum logic [2:0] {
    QIS_IDLE = 3'b000,
    QIS_LOAD = 3'b001,
    QIS_WAIT_ACK = 3'b010,
    QIS_WAIT_RS = 3'b011,
    QIS_ADVANCE = 3'b100,
    QIS_FINISH = 3'b101
  } qis_state_e;

  typedef struct packed {
    logic req;
    logic write;
    logic [1:0] start;
    logic [3:0] words;
  } qis_req_s;

  typedef struct packed {
    logic fast;
    logic slow;
    logic imm;
  } qis_cyc_s;
endpackage : qis_pkg

// *** logic/qis_port_slice.sv ***
`timescale 1ns/1ns
// One memory port: holds the port acknowledge, read restart and data until selected,
// and runs the write enable / write pulse timing for that port.
module qis_port_slice #(
  parameter int DATA_W = qis_pkg::DATA_W,
  parameter int PULSE_DLY = qis_pkg::WR_PULSE_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic write_mode,
  input wire logic port_ack,
  input wire logic port_rs,
  input wire logic [DATA_W-1:0] port_rdata,
  input wire logic strobe,
  input wire logic [DATA_W-1:0] proc_wdata,
  output logic ack_held,
  output logic rs_held,
  output logic [DATA_W-1:0] buffer,
  output logic write_enable,
  output logic write_pulse
);
  logic [3:0] pulse_cnt;
  logic loaded;
  logic pulse_due;

  if (PULSE_DLY < 1 || PULSE_DLY > 15) begin : g_bad_dly
    $error("qis_port_slice: PULSE_DLY out of range");
  end

  assign pulse_due = write_enable && pulse_cnt == 4'h1;

  // Event latches; a new event in the clearing cycle wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_held <= 1'b0;
      rs_held <= 1'b0;
    end else begin
      ack_held <= port_ack | (ack_held & ~clear & ~pulse_due);
      rs_held <= port_rs | (rs_held & ~clear);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      buffer <= '0;
    end else if (write_mode && strobe) begin
      buffer <= proc_wdata;
    end else if (!write_mode && port_ack) begin
      buffer <= port_rdata;
    end else if (clear && !write_mode) begin
      buffer <= '0;
    end
  end

  // Word owed to this port; an early port acknowledge must not write a stale buffer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      loaded <= 1'b0;
    end else if (write_mode && strobe) begin
      loaded <= 1'b1;
    end else if (pulse_due) begin
      loaded <= 1'b0;
    end
  end

  // Write enable once acknowledged and loaded, pulse after the delay
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      write_enable <= 1'b0;
      pulse_cnt <= '0;
      write_pulse <= 1'b0;
    end else begin
      write_pulse <= 1'b0;
      if (write_mode && loaded && (port_ack || ack_held) && !write_enable) begin
        write_enable <= 1'b1;
        pulse_cnt <= 4'(PULSE_DLY);
      end else if (write_enable) begin
        if (pulse_due) begin
          write_enable <= 1'b0;
          write_pulse <= 1'b1;
        end
        pulse_cnt <= pulse_cnt - 4'h1;
      end
    end
  end
endmodule : qis_port_slice

// *** logic/qis_sequencer.sv ***
`timescale 1ns/1ns
module qis_sequencer #(
  parameter int DATA_W = qis_pkg::DATA_W,
  parameter int ADV_DLY = qis_pkg::ADV_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire qis_pkg::qis_req_s req_in,
  input wire logic phase_b,
  input wire logic [DATA_W-1:0] proc_wdata,
  output logic proc_ack_a,
  output logic proc_ack_b,
  output logic data_valid_a,
  output logic data_valid_b,
  output logic [DATA_W-1:0] proc_rdata,
  output logic proc_rdata_en,
  output logic request_error,
  output logic busy,
  output qis_pkg::qis_cyc_s [3:0] memory_cycle_request,
  output logic [3:0][1:0] port_low_addr,
  input wire logic [3:0] port_ack,
  input wire logic [3:0] read_restart,
  input wire logic [3:0] port_busy,
  input wire logic [3:0][DATA_W-1:0] port_rdata,
  output logic [3:0][DATA_W-1:0] port_wdata,
  output logic [3:0] port_data_drive_enable,
  output logic [3:0] write_restart,
  output logic [3:0] write_enable
);
  // The advance counter is four bits wide
  if (ADV_DLY < 1 || ADV_DLY > 15) begin : g_bad_adv
    $error("qis_sequencer: ADV_DLY out of range");
  end

  // ----------------------------------------
  // Next requested word, modulo 4
  // ----------------------------------------
  function automatic logic [1:0] next_word(input logic [1:0] cur, input logic [3:0] pend);
    logic [1:0] cand;
    next_word = cur;
    for (int i = 3; i >= 1; i--) begin
      cand = 2'(cur + 2'(i));
      if (pend[cand]) next_word = cand;
    end
  endfunction : next_word

  // Request mask without the word at the counter
  function automatic logic [3:0] drop_word(input logic [3:0] pend, input logic [1:0] cur);
    drop_word = pend & ~(4'h1 << cur);
  endfunction : drop_word

  qis_pkg::qis_state_e state;
  logic is_write;
  logic [1:0] counter;
  logic [1:0] latched_port_select;
  logic [3:0] word_pending;
  logic [3:0] word_todo;
  logic any_word_pending;
  logic request_done_flag;
  logic first_word_loaded;
  logic cycling_flag;
  logic delayed_acknowledge;
  logic rs_sync;
  logic [3:0] adv_cnt;
  logic [3:0] ack_held;
  logic [3:0] rs_held;
  logic [3:0] slice_clear;
  logic [3:0] buffer_write_strobe;
  logic [3:0] write_pulse;
  logic sel_ack;
  logic sel_rs;
  logic all_idle;
  logic adv_last;
  logic [3:0][DATA_W-1:0] bufs;
  logic [3:0][DATA_W-1:0] port_wdata_r;

  assign any_word_pending = word_pending != qis_pkg::NO_WORDS;
  assign all_idle = port_busy == 4'h0;
  // While cycling, later write acknowledges are made internally
  assign sel_ack = is_write ? (cycling_flag | ack_held[counter]) : ack_held[counter];
  assign sel_rs = rs_held[counter];
  assign busy = state != qis_pkg::QIS_IDLE;
  assign port_wdata = port_wdata_r;
  assign adv_last = state == qis_pkg::QIS_ADVANCE && adv_cnt == 4'h1;

  // ----------------------------------------
  // Port slices
  // ----------------------------------------
  for (genvar p = 0; p < 4; p++) begin : g_port
    qis_port_slice #(.DATA_W(DATA_W)) u_slice (
      .clk(clk),
      .rst(rst),
      .clear(slice_clear[p]),
      .write_mode(is_write),
      .port_ack(port_ack[p]),
      .port_rs(read_restart[p]),
      .port_rdata(port_rdata[p]),
      .strobe(buffer_write_strobe[p]),
      .proc_wdata(proc_wdata),
      .ack_held(ack_held[p]),
      .rs_held(rs_held[p]),
      .buffer(bufs[p]),
      .write_enable(write_enable[p]),
      .write_pulse(write_pulse[p])
    );
    assign port_low_addr[p] = 2'(p);
    assign port_wdata_r[p] = write_pulse[p] ? bufs[p] : '0;
    assign write_restart[p] = write_pulse[p];
    // Cycle request only for pending words; writes wait for the first buffered word
    assign memory_cycle_request[p].fast = word_pending[p] & (~is_write | first_word_loaded);
    assign memory_cycle_request[p].slow = memory_cycle_request[p].fast;
    assign memory_cycle_request[p].imm = memory_cycle_request[p].fast;
    assign port_data_drive_enable[p] = delayed_acknowledge & ~is_write &
      (latched_port_select == 2'(p));
    assign slice_clear[p] = adv_last && counter == 2'(p);
    // Later words are on the data lines when their internal acknowledge is made
    assign buffer_write_strobe[p] = is_write && counter == 2'(p) &&
      (state == qis_pkg::QIS_LOAD ||
       (state == qis_pkg::QIS_WAIT_ACK && sel_ack && cycling_flag));
  end

  // ----------------------------------------
  // Sequence control
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= qis_pkg::QIS_IDLE;
      is_write <= 1'b0;
      counter <= qis_pkg::WORD0;
      adv_cnt <= '0;
      request_error <= 1'b0;
    end else begin
      unique case (state)
        qis_pkg::QIS_IDLE: begin
          if (req_in.req) begin
            request_error <= ~req_in.words[req_in.start];
            if (req_in.words[req_in.start]) begin
              counter <= req_in.start;
              is_write <= req_in.write;
              state <= req_in.write ? qis_pkg::QIS_LOAD : qis_pkg::QIS_WAIT_ACK;
            end
          end
        end
        qis_pkg::QIS_LOAD: state <= qis_pkg::QIS_WAIT_ACK;
        qis_pkg::QIS_WAIT_ACK: begin
          if (sel_ack) state <= is_write ? qis_pkg::QIS_ADVANCE : qis_pkg::QIS_WAIT_RS;
          adv_cnt <= 4'(ADV_DLY);
        end
        qis_pkg::QIS_WAIT_RS: begin
          if (sel_rs) state <= qis_pkg::QIS_ADVANCE;
          adv_cnt <= 4'(ADV_DLY);
        end
        qis_pkg::QIS_ADVANCE: begin
          adv_cnt <= adv_cnt - 4'h1;
          if (adv_last) begin
            counter <= next_word(counter, drop_word(word_todo, counter));
            state <= (word_todo == (4'h1 << counter)) ? qis_pkg::QIS_FINISH
                                                      : qis_pkg::QIS_WAIT_ACK;
          end
        end
        qis_pkg::QIS_FINISH: begin
          // Reads end on done flag; writes wait for every port to go idle
          if (!any_word_pending && (is_write ? all_idle : request_done_flag))
            state <= qis_pkg::QIS_IDLE;
        end
        default: state <= qis_pkg::QIS_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Request latches
  // ----------------------------------------
  // Words still to visit with the counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      word_todo <= '0;
    end else if (state == qis_pkg::QIS_IDLE && req_in.req && req_in.words[req_in.start]) begin
      word_todo <= req_in.words;
    end else if (adv_last) begin
      word_todo <= drop_word(word_todo, counter);
    end
  end

  // A write word is only transferred at its port's write pulse, which may trail the visit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      word_pending <= '0;
    end else if (state == qis_pkg::QIS_IDLE && req_in.req && req_in.words[req_in.start]) begin
      word_pending <= req_in.words;
    end else if (is_write) begin
      word_pending <= word_pending & ~write_pulse;
    end else if (adv_last) begin
      word_pending <= drop_word(word_pending, counter);
    end
  end

  // ----------------------------------------
  // Flags
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      request_done_flag <= 1'b0;
      first_word_loaded <= 1'b0;
      cycling_flag <= 1'b0;
    end else begin
      if (state == qis_pkg::QIS_IDLE) request_done_flag <= 1'b0;
      else if (adv_last && word_todo == (4'h1 << counter))
        request_done_flag <= 1'b1;
      if (state == qis_pkg::QIS_IDLE) first_word_loaded <= 1'b0;
      else if (state == qis_pkg::QIS_LOAD) first_word_loaded <= 1'b1;
      if (is_write && delayed_acknowledge) cycling_flag <= 1'b1;
      else if (state == qis_pkg::QIS_FINISH && all_idle) cycling_flag <= 1'b0;
    end
  end

  // ----------------------------------------
  // Acknowledge, delayed acknowledge, select latch and phase steering
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      delayed_acknowledge <= 1'b0;
      latched_port_select <= qis_pkg::WORD0;
      rs_sync <= 1'b0;
      proc_ack_a <= 1'b0;
      proc_ack_b <= 1'b0;
      data_valid_a <= 1'b0;
      data_valid_b <= 1'b0;
    end else begin
      delayed_acknowledge <= state == qis_pkg::QIS_WAIT_ACK && sel_ack;
      if (state == qis_pkg::QIS_WAIT_ACK && sel_ack) latched_port_select <= counter;
      proc_ack_a <= state == qis_pkg::QIS_WAIT_ACK && sel_ack && !phase_b;
      proc_ack_b <= state == qis_pkg::QIS_WAIT_ACK && sel_ack && phase_b;
      rs_sync <= state == qis_pkg::QIS_WAIT_RS && sel_rs;
      data_valid_a <= rs_sync && !phase_b;
      data_valid_b <= rs_sync && phase_b;
    end
  end

  // ----------------------------------------
  // Data towards the processor, one word at a time
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      proc_rdata <= '0;
      proc_rdata_en <= 1'b0;
    end else begin
      proc_rdata_en <= 1'b0;
      for (int p = 0; p < 4; p++) begin
        if (port_data_drive_enable[p]) begin
          proc_rdata <= bufs[p];
          proc_rdata_en <= 1'b1;
        end
      end
    end
  end

endmodule : qis_sequencer

// *** dv/qis_sequencer_assertions.sv ***
`timescale 1ns/1ns
// ------------------------------------------
// Port-level checks for the word sequencer
// ------------------------------------------
module qis_sequencer_assertions (
  input wire logic clk,
  input wire logic rst,
  input wire qis_pkg::qis_req_s req_in,
  input wire logic phase_b,
  input wire logic proc_ack_a,
  input wire logic proc_ack_b,
  input wire logic data_valid_a,
  input wire logic data_valid_b,
  input wire logic proc_rdata_en,
  input wire logic request_error,
  input wire logic busy,
  input wire qis_pkg::qis_cyc_s [3:0] memory_cycle_request,
  input wire logic [3:0][1:0] port_low_addr,
  input wire logic [3:0] port_busy,
  input wire logic [3:0] port_data_drive_enable,
  input wire logic [3:0] write_restart,
  input wire logic [3:0] write_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // A request is only taken while idle
  wire logic take = !busy && req_in.req;
  wire logic start_ok = req_in.words[req_in.start];
  property p_low_addr; port_low_addr == 8'he4; endproperty
  a_low_addr: assert property (p_low_addr) else $error("Port low bits wrong");
  property p_rd_all;
    take && start_ok && !req_in.write && req_in.words == 4'hf |-> ##[1:2] memory_cycle_request == 12'hfff;
  endproperty
  a_rd_all: assert property (p_rd_all) else $error("Quad read not on all ports");
  property p_wr_hold; take && start_ok && req_in.write |=> memory_cycle_request == 12'h0; endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("Write requested before load");
  property p_err_set; take && !start_ok |=> request_error && !busy; endproperty
  a_err_set: assert property (p_err_set) else $error("Bad start word accepted");
  property p_err_quiet; request_error |-> memory_cycle_request == 12'h0; endproperty
  a_err_quiet: assert property (p_err_quiet) else $error("Port request after error");
  property p_idle_quiet; !busy |-> memory_cycle_request == 12'h0 && write_enable == 4'h0; endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("Port active while idle");
  property p_side_a; proc_ack_a || data_valid_a |-> !phase_b; endproperty
  a_side_a: assert property (p_side_a) else $error("Phase A used in phase B");
  property p_side_b; proc_ack_b || data_valid_b |-> phase_b; endproperty
  a_side_b: assert property (p_side_b) else $error("Phase B used in phase A");
  property p_drive_one; $onehot0(port_data_drive_enable); endproperty
  a_drive_one: assert property (p_drive_one) else $error("Two ports drive data");
  property p_wr_pulse; (write_restart & ~$past(write_enable)) == 4'h0; endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("Pulse without enable");
  property p_end_idle; $fell(busy) |-> port_busy == 4'h0; endproperty
  a_end_idle: assert property (p_end_idle) else $error("Ended with port busy");
  c_read: cover property (proc_rdata_en);
  c_write: cover property (write_restart != 4'h0);
  c_error: cover property (request_error);
endmodule : qis_sequencer_assertions

bind qis_sequencer qis_sequencer_assertions u_chk (.clk(clk), .rst(rst), .req_in(req_in),
  .phase_b(phase_b), .proc_ack_a(proc_ack_a), .proc_ack_b(proc_ack_b),
  .data_valid_a(data_valid_a), .data_valid_b(data_valid_b), .proc_rdata_en(proc_rdata_en),
  .request_error(request_error), .busy(busy), .memory_cycle_request(memory_cycle_request),
  .port_low_addr(port_low_addr), .port_busy(port_busy),
  .port_data_drive_enable(port_data_drive_enable), .write_restart(write_restart),
  .write_enable(write_enable));

// *** dv/qis_mem_model.sv ***
`timescale 1ns/1ns
// ------------------------------------------
// Four storage ports with random answer times
// ------------------------------------------
module qis_mem_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr,
  input wire logic [qis_pkg::DATA_W-1:0] base,
  input wire qis_pkg::qis_cyc_s [3:0] memory_cycle_request,
  input wire logic [3:0] write_restart,
  output logic [3:0] port_ack,
  output logic [3:0] read_restart,
  output logic [3:0] port_busy,
  output logic [3:0][qis_pkg::DATA_W-1:0] port_rdata
);
  int seed = 14841;
  int st[4];
  int cnt[4];
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      st = '{default: 0};
      cnt = '{default: 0};
      port_ack <= 4'h0;
      read_restart <= 4'h0;
      port_busy <= 4'h0;
      port_rdata <= '0;
    end else begin
      port_ack <= 4'h0;
      read_restart <= 4'h0;
      for (int p = 0; p < 4; p++) begin
        if (cnt[p] > 0) cnt[p]--;
        else case (st[p])
          0: if (memory_cycle_request[p].fast) begin
            st[p] = 1;
            cnt[p] = $unsigned($random(seed)) % 6;
          end
          1: begin
            port_ack[p] <= 1'b1;
            port_busy[p] <= 1'b1;
            port_rdata[p] <= base ^ qis_pkg::DATA_W'(p);
            st[p] = 2;
            cnt[p] = wr ? 0 : $unsigned($random(seed)) % 5;
          end
          2: if (!wr || write_restart[p]) begin
            read_restart[p] <= !wr;
            st[p] = 3;
            cnt[p] = 2;
          end
          // Released data lines flip so a late capture is caught
          3: begin
            port_busy[p] <= 1'b0;
            port_rdata[p] <= ~port_rdata[p];
            st[p] = 4;
          end
          default: if (!memory_cycle_request[p].fast) st[p] = 0;
        endcase
      end
    end
  end
endmodule : qis_mem_model

// *** dv/quadword_interleave_sequencer_tb_top.sv ***
`timescale 1ns/1ns
// ------------------------------------------
// Self-checking bench for the word sequencer
// ------------------------------------------
module quadword_interleave_sequencer_tb_top;
  localparam int W = qis_pkg::DATA_W;
  logic clk = 1'b0;
  logic rst = 1'b1;
  qis_pkg::qis_req_s req_in = '0;
  logic phase_b = 1'b0;
  logic [W-1:0] proc_wdata = '0;
  logic [W-1:0] base = '0;
  logic [W-1:0] exp_q[$];
  logic [W-1:0] wq[$];
  logic proc_ack_a, proc_ack_b, data_valid_a, data_valid_b, proc_rdata_en, request_error, busy;
  logic [W-1:0] proc_rdata;
  qis_pkg::qis_cyc_s [3:0] memory_cycle_request;
  logic [3:0][1:0] port_low_addr;
  logic [3:0] port_ack, read_restart, port_busy, port_data_drive_enable, write_restart;
  logic [3:0] write_enable;
  // Write words still owed per port; a port writes once its word is loaded and it has answered
  logic [3:0] wr_mask = 4'h0;
  logic [3:0][W-1:0] port_rdata, port_wdata;
  int failures = 0;
  int total_checks = 0;
  int seed = 14841;
  int i;
  always #10 clk = ~clk;
  qis_sequencer u_dut (.clk(clk), .rst(rst), .req_in(req_in), .phase_b(phase_b),
    .proc_wdata(proc_wdata), .proc_ack_a(proc_ack_a), .proc_ack_b(proc_ack_b),
    .data_valid_a(data_valid_a), .data_valid_b(data_valid_b), .proc_rdata(proc_rdata),
    .proc_rdata_en(proc_rdata_en), .request_error(request_error), .busy(busy),
    .memory_cycle_request(memory_cycle_request), .port_low_addr(port_low_addr),
    .port_ack(port_ack), .read_restart(read_restart), .port_busy(port_busy),
    .port_rdata(port_rdata), .port_wdata(port_wdata),
    .port_data_drive_enable(port_data_drive_enable), .write_restart(write_restart),
    .write_enable(write_enable));
  qis_mem_model u_mem (.clk(clk), .rst(rst), .wr(req_in.write), .base(base),
    .memory_cycle_request(memory_cycle_request), .write_restart(write_restart),
    .port_ack(port_ack), .read_restart(read_restart), .port_busy(port_busy),
    .port_rdata(port_rdata));
  task automatic check(input logic [W-1:0] seen, input logic [W-1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic take(input logic [W-1:0] seen);
    if (exp_q.size() == 0) check(W'(exp_q.size()), W'(1));
    else check(seen, exp_q.pop_front());
  endtask : take
  task automatic tally_and_finish;
    if (failures == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  // Words are listed in the order they must appear; value encodes the port
  task automatic run(input logic wr, input logic [1:0] st, input logic [3:0] wd);
    int n;
    logic [1:0] p;
    logic [W-1:0] b;
    b = W'({$random(seed), $random(seed)});
    wr_mask = (wr && wd[st]) ? wd : 4'h0;
    for (n = 0; n < 4; n++) begin
      p = st + 2'(n);
      if (!wr && wd[st] && wd[p]) exp_q.push_back(b ^ W'(p));
      if (wd[st] && wd[p]) wq.push_back(b ^ W'(p));
    end
    base <= b;
    phase_b <= 1'($random(seed));
    proc_wdata <= b ^ W'(st);
    req_in <= '{req: 1'b1, write: wr, start: st, words: wd};
    @(posedge clk);
    req_in.req <= 1'b0;
    // Busy is looked at mid-cycle, away from the edge that updates it
    @(negedge clk);
    for (n = 0; n < 600 && busy !== 1'b0; n++) @(negedge clk);
    repeat (3) @(posedge clk);
    check(W'(busy), '0);
    check(W'(request_error), W'(!wd[st]));
    check(W'(exp_q.size()), '0);
    check(W'(wr_mask), '0);
    exp_q.delete();
    wq.delete();
  endtask : run
  always @(posedge clk) begin
    if ((proc_ack_a || proc_ack_b) && wq.size() > 1) begin
      void'(wq.pop_front());
      proc_wdata <= wq[0];
    end
  end
  always @(posedge clk) begin
    if (proc_rdata_en === 1'b1) take(proc_rdata);
    for (int p = 0; p < 4; p++) begin
      if (write_restart[p] === 1'b1) begin
        check(port_wdata[p], base ^ W'(p));
        check(W'(wr_mask[p]), W'(1'b1));
        wr_mask[p] = 1'b0;
      end
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    run(1'b0, 2'h0, 4'hf);
    run(1'b1, 2'h0, 4'hf);
    run(1'b0, 2'h3, 4'hb);
    run(1'b0, 2'h2, 4'h3);
    run(1'b1, 2'h3, 4'h9);
    for (i = 0; i < 16; i++) run(1'($random(seed)), 2'(i), 4'($random(seed)) | (4'h1 << (i % 4)));
    tally_and_finish();
  end
  // Runs need about a thousand cycles; the cut-off of 20000 cycles allows about twenty times that
  initial begin
    #400000;
    failures++;
    tally_and_finish();
  end
endmodule : quadword_interleave_sequencer_tb_top
